/* src/mlsf_flags.sv */
// Operation
// RL1 - program opens its parameter block with the setup flag contact at step 0
// RL2 - parameter block is taken in once, never on every scan
// RL3 - program sets port-select flag to use port 2; port 1 needs nothing
// RL4 - parameter-error flag per port raised on bad parameters for that port
// RL5 - error flag and error code stay held after link recovers
// RL6 - newer models clear errors on power cycle only; older on stop-to-run
// RL7 - program may never force setup, error, fault or busy flags on
// RL8 - eight station fault flags, master through slave 7, set on sequence error
// RL9 - a station never reports a sequence error against itself
// RL10 - transfer-active flag on while own station transfers data
// RL11 - port 1 error stores code, 6308 for bad parameters
// RL12 - port 2 error stores code, 3808 for bad parameters
// RL13 - station 0 is master, stations 1 to 7 are slaves
// RL14 - no response after retries counts as sequence error of that station
// RL15 - error flag and error code are updated in the same cycle
module mlsf_flags
  import mlsf_pkg::*;
#(
  parameter bit CLEAR_ON_RUN = 1'b0  // 1: older model, clear on stop-to-run
)(
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  wire mlsf_wb_req_t   wbReq,
  output logic                wbAck,
  output logic [31:0]         wbDatO,
  input  wire mlsf_link_evt_t linkEvt,
  input  wire logic [2:0]     ownStation,
  input  wire logic           runMode,
  output logic                portSelect,
  output logic                irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic                  setupMarker_q;
  logic                  setupTaken_q;
  logic                  portSel_q;
  logic                  p1Err_q;
  logic                  p2Err_q;
  logic [15:0]           p1Code_q;
  logic [15:0]           p2Code_q;
  logic [7:0]            fault_q;
  logic                  xfer_q;
  logic                  run_q;
  logic [MLSF_IRQ_W-1:0] irqStat_q;
  logic [MLSF_IRQ_W-1:0] irqEn_q;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic                  irq_q;

  logic                  busHit;
  logic                  wrStb;
  logic                  errClear;
  logic                  faultHit;
  logic [MLSF_IRQ_W-1:0] irqEvt;
  logic [MLSF_IRQ_W-1:0] irqClr;
  logic [7:0]            irqEnMerged;

  // one-hot decode of a station number, used by the fault path
  function automatic logic [7:0] stn_onehot(input logic [2:0] stn);
    logic [7:0] v;
    v = 8'h00;
    v[stn] = 1'b1;
    return v;
  endfunction : stn_onehot

  // byte-lane merge of write data into a narrow field
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input mlsf_wb_req_t r);
    return r.sel[0] ? r.dat[7:0] : old;
  endfunction : lane0

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  assign busHit = wbReq.cyc && wbReq.stb && !ack_q;
  // writes land on the edge at which the master samples ack, while it still
  // holds the request; a master that gives up early changes nothing
  assign wrStb  = wbReq.cyc && wbReq.stb && wbReq.we && ack_q;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_q <= 1'b0;
    else
      ack_q <= busHit;
  end

  // read mux; unmapped and write-only offsets read as zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dat_q <= 32'h0000_0000;
    else if (busHit && !wbReq.we)
    begin
      unique case (wbReq.adr)
        MLSF_CTRL_OFS:    dat_q <= {31'h0, portSel_q};
        MLSF_FLAGS_OFS:   dat_q <= {16'h0, fault_q, 4'h0, xfer_q, p2Err_q,
                                    p1Err_q, setupMarker_q};
        MLSF_P1CODE_OFS:  dat_q <= {16'h0, p1Code_q};
        MLSF_P2CODE_OFS:  dat_q <= {16'h0, p2Code_q};
        MLSF_IRQSTAT_OFS: dat_q <= {28'h0, irqStat_q};
        MLSF_IRQEN_OFS:   dat_q <= {28'h0, irqEn_q};
        default:          dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // program-writable control
  // ------------------------------------------------------------------
  // port select is the only writable flag; nothing the program writes
  // reaches the device-driven flags
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      portSel_q <= 1'b0;  // port 1 by default, no program action needed
    else if (wrStb && wbReq.adr == MLSF_CTRL_OFS && wbReq.sel[0])
      portSel_q <= wbReq.dat[0];  // RL3
  end

  // only the low lane carries enable bits; merged first, then narrowed
  assign irqEnMerged = lane0({4'h0, irqEn_q}, wbReq);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irqEn_q <= MLSF_IRQ_RST;
    else if (wrStb && wbReq.adr == MLSF_IRQEN_OFS)
      irqEn_q <= irqEnMerged[MLSF_IRQ_W-1:0];
  end

  // ------------------------------------------------------------------
  // parameter setup
  // ------------------------------------------------------------------
  // marker is on from reset until the engine reports the block done;
  // later done pulses are ignored so setup never reruns per scan
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      setupMarker_q <= 1'b1;  // RL1
      setupTaken_q  <= 1'b0;
    end
    else if (linkEvt.setupDone && !setupTaken_q)
    begin
      setupMarker_q <= 1'b0;  // RL2
      setupTaken_q  <= 1'b1;  // RL2
    end
  end

  // ------------------------------------------------------------------
  // serial error flags and codes
  // ------------------------------------------------------------------
  // old-model clear comes from a stop-to-run edge of the mode level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      run_q <= 1'b1;  // read as running, so leaving reset in run is no false edge
    else
      run_q <= runMode;
  end

  assign errClear = CLEAR_ON_RUN && runMode && !run_q;  // RL6

  // flag and code share one process so they always move together;
  // a new error in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p1Err_q  <= 1'b0;
      p1Code_q <= MLSF_CODE_RST;
    end
    else if (linkEvt.p1ParamBad)
    begin
      p1Err_q  <= 1'b1;                // RL4
      p1Code_q <= MLSF_P1_PARAM_CODE;  // RL11 RL15
    end
    else if (linkEvt.p1CommErr)
    begin
      p1Err_q  <= 1'b1;                // RL15
      p1Code_q <= linkEvt.commCode;    // RL11
    end
    else if (errClear)
    begin
      p1Err_q  <= 1'b0;                // RL5
      p1Code_q <= MLSF_CODE_RST;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p2Err_q  <= 1'b0;
      p2Code_q <= MLSF_CODE_RST;
    end
    else if (linkEvt.p2ParamBad)
    begin
      p2Err_q  <= 1'b1;                // RL4
      p2Code_q <= MLSF_P2_PARAM_CODE;  // RL12 RL15
    end
    else if (linkEvt.p2CommErr)
    begin
      p2Err_q  <= 1'b1;                // RL15
      p2Code_q <= linkEvt.commCode;    // RL12
    end
    else if (errClear)
    begin
      p2Err_q  <= 1'b0;                // RL5
      p2Code_q <= MLSF_CODE_RST;
    end
  end

  // ------------------------------------------------------------------
  // station faults and transfer activity
  // ------------------------------------------------------------------
  // a station that stops answering arrives here as an ordinary fault event
  // a fault naming our own number is dropped: we cannot see our own
  assign faultHit = linkEvt.faultEvt && linkEvt.faultStation != ownStation;  // RL9

  // bit 0 is the master, bits 1..7 the slaves; sticky like the errors
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fault_q <= MLSF_FAULT_RST;
    else if (faultHit)
      fault_q <= fault_q | stn_onehot(linkEvt.faultStation);  // RL8 RL13 RL14
    else if (errClear)
      fault_q <= MLSF_FAULT_RST;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      xfer_q <= 1'b0;
    else
      xfer_q <= linkEvt.xferBusy;  // RL10
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  assign irqEvt[MLSF_IRQ_P1ERR] = linkEvt.p1ParamBad || linkEvt.p1CommErr;
  assign irqEvt[MLSF_IRQ_P2ERR] = linkEvt.p2ParamBad || linkEvt.p2CommErr;
  assign irqEvt[MLSF_IRQ_FAULT] = faultHit;
  // transfer end is the fall of the busy level against last cycle's flag
  assign irqEvt[MLSF_IRQ_XDONE] = xfer_q && !linkEvt.xferBusy;
  assign irqClr = (wrStb && wbReq.adr == MLSF_IRQCLR_OFS && wbReq.sel[0])
                  ? wbReq.dat[MLSF_IRQ_W-1:0] : MLSF_IRQ_RST;

  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irqStat_q <= MLSF_IRQ_RST;
    else
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
  end

  // level output, one cycle behind the status it reflects
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(irqStat_q & irqEn_q);
  end

  assign wbAck      = ack_q;
  assign wbDatO     = dat_q;
  assign portSelect = portSel_q;
  assign irq        = irq_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // setup, errors and codes, station faults, transfer flag, bus ack and port select
  setup_once_a: assert property (!setupMarker_q |=> !setupMarker_q) // RL2
    else $error("setup marker rose again");
  p1_code_a: assert property (linkEvt.p1ParamBad
      |=> p1Err_q && p1Code_q == 16'h18a4) // RL11
    else $error("port 1 param code wrong");
  p2_code_a: assert property (linkEvt.p2ParamBad
      |=> p2Err_q && p2Code_q == 16'h0ee0) // RL12
    else $error("port 2 param code wrong");
  err_held_a: assert property (p1Err_q && !errClear && !linkEvt.p1ParamBad
      && !linkEvt.p1CommErr |=> p1Err_q && $stable(p1Code_q)) // RL5
    else $error("port 1 error not held");
  new_clear_a: assert property (!CLEAR_ON_RUN && p2Err_q |=> p2Err_q) // RL6
    else $error("error cleared without power cycle");
  own_fault_a: assert property (linkEvt.faultEvt
      && linkEvt.faultStation == ownStation
      |=> fault_q[ownStation] == $past(fault_q[ownStation])) // RL9
    else $error("own station fault reported");
  fault_set_a: assert property (faultHit
      |=> fault_q[$past(linkEvt.faultStation)]) // RL8
    else $error("station fault not set");
  xfer_flag_a: assert property (linkEvt.xferBusy ##1 linkEvt.xferBusy
      |-> xfer_q ##1 xfer_q) // RL10
    else $error("transfer flag not held");
  flag_code_a: assert property ($rose(p1Err_q)
      |-> p1Code_q == ($past(linkEvt.p1ParamBad) ? MLSF_P1_PARAM_CODE
                                                 : $past(linkEvt.commCode))) // RL15
    else $error("flag moved without code");
  ack_pulse_a: assert property (wbReq.cyc && wbReq.stb && !wbAck
      |=> wbAck ##1 !wbAck)
    else $error("bus ack timing wrong");
  port_sel_a: assert property (wrStb && wbReq.adr == MLSF_CTRL_OFS
      && wbReq.sel[0] |=> portSelect == $past(wbReq.dat[0])) // RL3
    else $error("port select not written");

  // interrupt and transfer bookkeeping, older-model clearing
  irq_level_a: assert property (irq == $past(|(irqStat_q & irqEn_q)))
    else $error("interrupt level does not follow status");
  fault_irq_a: assert property (faultHit |=> irqStat_q[MLSF_IRQ_FAULT]) // RL8
    else $error("fault event lost in status");
  xfer_done_a: assert property (xfer_q && !linkEvt.xferBusy
      |=> irqStat_q[MLSF_IRQ_XDONE] && !xfer_q) // RL10
    else $error("transfer end not recorded");
  xfer_idle_a: assert property (!linkEvt.xferBusy |=> !xfer_q) // RL10
    else $error("transfer flag on while idle");
  old_clear_a: assert property (errClear && !linkEvt.p1ParamBad && !linkEvt.p1CommErr
      |=> !p1Err_q && p1Code_q == MLSF_CODE_RST) // RL6
    else $error("stop-to-run did not clear port 1 error");
  fault_clear_a: assert property (errClear && !faultHit
      |=> fault_q == MLSF_FAULT_RST) // RL6
    else $error("stop-to-run did not clear station faults");

  setup_cov_c: cover property ($fell(setupMarker_q));
  p1_err_c:    cover property ($rose(p1Err_q) ##[1:20] irq);
  fault_c:     cover property (faultHit ##1 fault_q != 8'h00);
  xfer_c:      cover property ($rose(xfer_q) ##[1:50] $fell(xfer_q));
  clear_c:     cover property (errClear && p1Err_q);

endmodule : mlsf_flags

/* src/mlsf_pkg.sv */
package mlsf_pkg;

  // ------------------------------------------------------------------
  // register map, byte addresses on a 32-bit classic bus
  // ------------------------------------------------------------------
  localparam logic [7:0] MLSF_CTRL_OFS    = 8'h00;
  localparam logic [7:0] MLSF_FLAGS_OFS   = 8'h04;
  localparam logic [7:0] MLSF_P1CODE_OFS  = 8'h08;
  localparam logic [7:0] MLSF_P2CODE_OFS  = 8'h0c;
  localparam logic [7:0] MLSF_IRQSTAT_OFS = 8'h10;
  localparam logic [7:0] MLSF_IRQCLR_OFS  = 8'h14;
  localparam logic [7:0] MLSF_IRQEN_OFS   = 8'h18;

  // flags register field positions
  localparam int MLSF_SETUP_BIT  = 0;
  localparam int MLSF_P1ERR_BIT  = 1;
  localparam int MLSF_P2ERR_BIT  = 2;
  localparam int MLSF_XFER_BIT   = 3;
  localparam int MLSF_FAULT_LSB  = 8;

  // interrupt bit positions
  localparam int MLSF_IRQ_P1ERR  = 0;
  localparam int MLSF_IRQ_P2ERR  = 1;
  localparam int MLSF_IRQ_FAULT  = 2;
  localparam int MLSF_IRQ_XDONE  = 3;
  localparam int MLSF_IRQ_W      = 4;

  // error codes stored on bad network parameters (decimal 6308 / 3808)
  localparam logic [15:0] MLSF_P1_PARAM_CODE = 16'h18a4;
  localparam logic [15:0] MLSF_P2_PARAM_CODE = 16'h0ee0;

  // reset values
  localparam logic [15:0] MLSF_CODE_RST = 16'h0000;
  localparam logic [7:0]  MLSF_FAULT_RST = 8'h00;
  localparam logic [MLSF_IRQ_W-1:0] MLSF_IRQ_RST = 4'h0;
  localparam int MLSF_STATIONS = 8;

  // bus request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } mlsf_wb_req_t;

  // events from the link engine, same clock domain
  typedef struct packed {
    logic        setupDone;
    logic        p1ParamBad;
    logic        p2ParamBad;
    logic        p1CommErr;
    logic        p2CommErr;
    logic [15:0] commCode;
    logic        faultEvt;
    logic [2:0]  faultStation;
    logic        xferBusy;
  } mlsf_link_evt_t;

endpackage : mlsf_pkg

/* tb/mlsf_link_model.sv */
module mlsf_link_model
  import mlsf_pkg::*;
(
  input  wire logic      clk,
  output mlsf_link_evt_t linkEvt
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------
  // far stations and link engine
  // ----------------------------------------------------------

  // quiet link after power-up
  initial linkEvt = '0;

  // one-cycle event; idle code is inverted so a stale code never reads valid
  task automatic fire(input int k, input logic [15:0] c, input logic [2:0] s);
    mlsf_link_evt_t e;
    e              = '0;
    e.xferBusy     = linkEvt.xferBusy;
    e.setupDone    = (k == 0);
    e.p1ParamBad   = (k == 1);
    e.p2ParamBad   = (k == 2);
    e.p1CommErr    = (k == 3);
    e.p2CommErr    = (k == 4);
    e.faultEvt     = (k == 5);
    e.commCode     = c;
    e.faultStation = s;
    @(posedge clk);
    linkEvt <= e;
    @(posedge clk);
    e          = '0;
    e.xferBusy = linkEvt.xferBusy;
    e.commCode = ~c;
    linkEvt   <= e;
  endtask : fire

  // transfer level, held until changed
  task automatic hold(input logic b);
    @(posedge clk);
    linkEvt.xferBusy <= b;
  endtask : hold
endmodule : mlsf_link_model

/* tb/test_multidrop_link_status_flags.sv */
module test_multidrop_link_status_flags
  import mlsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic           clk         = 1'b0;
  logic           arst_n      = 1'b0;
  mlsf_wb_req_t   wbReq       = '0;
  logic           wbAck;
  logic [31:0]    wbDatO;
  logic [31:0]    oldDatO;
  logic [31:0]    oldRd;
  mlsf_link_evt_t linkEvt;
  logic [2:0]     ownStation  = 3'h3;
  logic           runMode     = 1'b1;
  logic           portSelect;
  logic           irq;
  logic [31:0]    rd;
  int             fails       = 0;
  int             comparisons = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  mlsf_flags #(.CLEAR_ON_RUN(1'b0)) DUT (
    .clk        (clk),
    .arst_n     (arst_n),
    .wbReq      (wbReq),
    .wbAck      (wbAck),
    .wbDatO     (wbDatO),
    .linkEvt    (linkEvt),
    .ownStation (ownStation),
    .runMode    (runMode),
    .portSelect (portSelect),
    .irq        (irq)
  );

  // older model beside it: same bus and link, clears errors on stop-to-run
  mlsf_flags #(.CLEAR_ON_RUN(1'b1)) dutOld (
    .clk        (clk),
    .arst_n     (arst_n),
    .wbReq      (wbReq),
    .wbAck      (),
    .wbDatO     (oldDatO),
    .linkEvt    (linkEvt),
    .ownStation (ownStation),
    .runMode    (runMode),
    .portSelect (),
    .irq        ()
  );

  mlsf_link_model link (
    .clk     (clk),
    .linkEvt (linkEvt)
  );

  // ----------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // classic cycle; request held until ack is seen, only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    do
      @(posedge clk);
    while (wbAck !== 1'b1);
    rd    = wbDatO;
    oldRd = oldDatO;
    wbReq <= '0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset

  task automatic note(input string s);
    $display("test %s done, fails %0d", s, fails);
  endtask : note

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------

  // main sequence; flags accumulate, so order of tests matters
  initial
  begin
    do_reset();
    rdc(MLSF_FLAGS_OFS, 32'h1);
    rdc(MLSF_CTRL_OFS, 32'h0);
    rdc(MLSF_P1CODE_OFS, 32'h0);
    rdc(MLSF_IRQSTAT_OFS, 32'h0);
    note("reset");
    link.fire(0, 16'h0, 3'h0);
    rdc(MLSF_FLAGS_OFS, 32'h0);
    wb(1'b1, MLSF_FLAGS_OFS, 32'hffffffff);
    link.fire(0, 16'h0, 3'h0);
    rdc(MLSF_FLAGS_OFS, 32'h0);
    note("setup");
    wb(1'b1, MLSF_CTRL_OFS, 32'h1);
    rdc(MLSF_CTRL_OFS, 32'h1);
    chk({31'h0, portSelect}, 32'h1);
    note("port");
    wb(1'b1, MLSF_IRQEN_OFS, 32'hf);
    rdc(MLSF_IRQEN_OFS, 32'hf);
    link.fire(1, 16'h5555, 3'h0);
    rdc(MLSF_FLAGS_OFS, 32'h2);
    rdc(MLSF_P1CODE_OFS, 32'h18a4);
    chk({31'h0, irq}, 32'h1);
    link.fire(2, 16'h5555, 3'h0);
    rdc(MLSF_FLAGS_OFS, 32'h6);
    rdc(MLSF_P2CODE_OFS, 32'h0ee0);
    link.fire(4, 16'h0abc, 3'h0);
    rdc(MLSF_P2CODE_OFS, 32'h0abc);
    chk(oldRd, 32'h0abc);
    // stop then run: the newer model keeps its errors, the older one clears
    @(posedge clk);
    runMode <= 1'b0;
    repeat (3) @(posedge clk);
    runMode <= 1'b1;
    rdc(MLSF_FLAGS_OFS, 32'h6);
    chk(oldRd, 32'h0);
    rdc(MLSF_P1CODE_OFS, 32'h18a4);
    chk(oldRd, 32'h0);
    note("errors");
    for (int s = 0; s < 8; s++)
      link.fire(5, 16'h0, 3'(s));
    rdc(MLSF_FLAGS_OFS, 32'hf706);
    chk(oldRd, 32'hf700);
    link.hold(1'b1);
    rdc(MLSF_FLAGS_OFS, 32'hf70e);
    link.hold(1'b0);
    rdc(MLSF_FLAGS_OFS, 32'hf706);
    rdc(MLSF_IRQSTAT_OFS, 32'hf);
    note("faults");
    wb(1'b1, MLSF_IRQCLR_OFS, 32'hf);
    rdc(MLSF_IRQSTAT_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, MLSF_IRQEN_OFS, 32'h0);
    link.fire(1, 16'h0, 3'h0);
    rdc(MLSF_IRQSTAT_OFS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, MLSF_IRQEN_OFS, 32'h1);
    rdc(MLSF_IRQEN_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(8'h1c, 32'h0);
    note("irq");
    do_reset();
    rdc(MLSF_FLAGS_OFS, 32'h1);
    rdc(MLSF_P2CODE_OFS, 32'h0);
    note("power cycle");
    give_verdict();
  end

  // watchdog, well beyond the roughly 160 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule : test_multidrop_link_status_flags
